// File: hdl/lcd_command_decoder.sv
// lcd_command_decoder: command and data port of a dot-matrix lcd driver
// assumes: async host strobes, one clock, display ram in a submodule
//
// Function
// - power command loads booster, regulator, follower
// - ratio command loads three bits, seven external
// - contrast code is inverted into factor
// - bias bit picks eighth or sixth
// - display off plus all-on means saver
// - saver stops oscillator, supplies, grounds drivers
// - saver keeps ram, settings and host access
// - e2 resets settings, e3 does nothing
// - test mode cleared by reset or display
// - display command turns display off or on
// - reverse bit inverts pixel polarity
// - all-on bit forces every pixel lit
// - page command loads four bit page
// - column pointer loaded in two halves
// - start line command loads six bits
// - segment direction normal or mirrored
// - common direction bit three, low bits ignored
// - rmw mode: writes advance, reads hold
// - end command leaves rmw mode
// - end restores column, not page
// - column wraps after last, page advances
`timescale 1ns/1ns
module lcd_command_decoder (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmdDataSelect,
  input wire logic hostReadStrobeN,
  input wire logic hostWriteStrobeN,
  input wire logic [7:0] hostDataIn,
  output logic [7:0] hostDataOut,
  output logic hostDataOe,
  output logic displayOn,
  output logic displayReverse,
  output logic allPointsOn,
  output logic powerSaver,
  output logic oscEnable,
  output logic boosterOn,
  output logic regulatorOn,
  output logic followerOn,
  output logic [2:0] regulatorRatio,
  output logic externalResistor,
  output logic [4:0] contrastCode,
  output logic [4:0] contrastFactor,
  output logic biasSixth,
  output logic biasActive,
  output logic segmentMirror,
  output logic commonReverse,
  output logic [5:0] startLine,
  output logic [3:0] pagePtr,
  output logic [6:0] columnPtr,
  output logic rmwActive,
  output logic testMode,
  output logic driversGrounded
);
  // ==========================================================
  // pin synchronisers
  logic [1:0] wrSync_q; // write strobe, bit 1 is usable
  logic [1:0] rdSync_q; // read strobe, bit 1 is usable
  logic [1:0] selSync_q; // command/data select
  logic [7:0] dataSync1_q; // data bus first stage
  logic [7:0] dataSync2_q; // data bus second stage
  logic wrLast_q; // previous synced write strobe
  logic rdLast_q; // previous synced read strobe

  // two flops on every pin before any logic looks at it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrSync_q <= 2'h3;
      rdSync_q <= 2'h3;
      selSync_q <= 2'h0;
      dataSync1_q <= 8'h00;
      dataSync2_q <= 8'h00;
    end else begin
      wrSync_q <= {wrSync_q[0], hostWriteStrobeN};
      rdSync_q <= {rdSync_q[0], hostReadStrobeN};
      selSync_q <= {selSync_q[0], cmdDataSelect};
      dataSync1_q <= hostDataIn;
      dataSync2_q <= dataSync1_q;
    end
  end

  // edge history reads only the second stages
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrLast_q <= 1'b1;
      rdLast_q <= 1'b1;
    end else begin
      wrLast_q <= wrSync_q[1];
      rdLast_q <= rdSync_q[1];
    end
  end

  // ==========================================================
  // transfer events
  logic wrDone; // write strobe released
  logic rdStart; // read strobe asserted
  logic cmdTake; // command byte taken
  logic dataWrTake; // display data written
  logic dataRdTake; // display data read
  logic [7:0] cmd; // byte of the transfer
  logic [7:0] dataOut_q; // byte on the bus during a read
  logic [7:0] readBuf_q; // prefetched byte for the next read
  logic rdPend_q; // ram answer arrives this cycle

  // data is sampled at the trailing edge of the write strobe
  assign wrDone = wrSync_q[1] & ~wrLast_q;
  assign rdStart = ~rdSync_q[1] & rdLast_q;
  assign cmd = dataSync2_q;
  assign cmdTake = wrDone & ~selSync_q[1];
  assign dataWrTake = wrDone & selSync_q[1];
  assign dataRdTake = rdStart & selSync_q[1];

  // ==========================================================
  // command decode, each pattern looks only at its own bits
  logic isDisplay, isReverse, isAllOn, isBias, isSegDir;
  logic isPage, isColHi, isColLo, isStart, isVolume;
  logic isPower, isRatio, isComDir, isRmw, isEnd;
  logic isReset, isTest;

  assign isDisplay = cmdTake && cmd[7:1] == lcdcd_pkg::OP_DISPLAY;
  assign isReverse = cmdTake && cmd[7:1] == lcdcd_pkg::OP_REVERSE;
  assign isAllOn = cmdTake && cmd[7:1] == lcdcd_pkg::OP_ALLON;
  assign isBias = cmdTake && cmd[7:1] == lcdcd_pkg::OP_BIAS;
  assign isSegDir = cmdTake && cmd[7:1] == lcdcd_pkg::OP_SEGDIR;
  assign isPage = cmdTake && cmd[7:4] == lcdcd_pkg::OP_PAGE;
  assign isColHi = cmdTake && cmd[7:4] == lcdcd_pkg::OP_COLHI;
  assign isColLo = cmdTake && cmd[7:4] == lcdcd_pkg::OP_COLLO;
  assign isStart = cmdTake && cmd[7:6] == lcdcd_pkg::OP_START;
  assign isVolume = cmdTake && cmd[7:5] == lcdcd_pkg::OP_VOLUME;
  assign isPower = cmdTake && cmd[7:3] == lcdcd_pkg::OP_POWER;
  assign isRatio = cmdTake && cmd[7:3] == lcdcd_pkg::OP_RATIO;
  assign isComDir = cmdTake && cmd[7:4] == lcdcd_pkg::OP_COMDIR[4:1];
  assign isRmw = cmdTake && cmd == lcdcd_pkg::CMD_RMW;
  assign isEnd = cmdTake && cmd == lcdcd_pkg::CMD_END;
  assign isReset = cmdTake && cmd == lcdcd_pkg::CMD_RESET;
  // the nop byte and all unmatched bytes fall through untouched
  assign isTest = cmdTake && (cmd & lcdcd_pkg::TEST_MASK) == lcdcd_pkg::TEST_VALUE;

  // ==========================================================
  // display mode settings
  logic displayOn_q, reverse_q, allOn_q, segMirror_q, comReverse_q;
  logic [5:0] startLine_q;

  // soft reset returns every setting to its pin-reset value
  always_ff @(posedge clk) begin
    if (!rst_n || isReset) begin
      displayOn_q <= 1'b0;
      reverse_q <= 1'b0;
      allOn_q <= 1'b0;
      segMirror_q <= 1'b0;
      comReverse_q <= 1'b0;
      startLine_q <= lcdcd_pkg::RST_START;
    end else begin
      if (isDisplay) displayOn_q <= cmd[0];
      if (isReverse) reverse_q <= cmd[0];
      if (isAllOn) allOn_q <= cmd[0];
      if (isSegDir) segMirror_q <= cmd[0];
      if (isComDir) comReverse_q <= cmd[3];
      if (isStart) startLine_q <= cmd[5:0];
    end
  end

  // ==========================================================
  // power supply settings
  logic booster_q, regulator_q, follower_q, bias_q;
  logic [2:0] ratio_q;
  logic [4:0] contrast_q;

  // settings are kept through power saver, only their effect is gated
  always_ff @(posedge clk) begin
    if (!rst_n || isReset) begin
      booster_q <= 1'b0;
      regulator_q <= 1'b0;
      follower_q <= 1'b0;
      bias_q <= 1'b0;
      ratio_q <= lcdcd_pkg::RST_RATIO;
      contrast_q <= lcdcd_pkg::RST_CONTRAST;
    end else begin
      if (isPower) begin
        booster_q <= cmd[2];
        regulator_q <= cmd[1];
        follower_q <= cmd[0];
      end
      if (isRatio) ratio_q <= cmd[2:0];
      if (isVolume) contrast_q <= cmd[4:0];
      if (isBias) bias_q <= cmd[0];
    end
  end

  // ==========================================================
  // power saver and derived outputs
  logic saver;

  // no opcode of its own: the two display settings together
  assign saver = ~displayOn_q & allOn_q;
  assign powerSaver = saver;
  assign oscEnable = ~saver;
  assign boosterOn = booster_q & ~saver;
  assign regulatorOn = regulator_q & ~saver;
  assign followerOn = follower_q & ~saver;
  assign driversGrounded = saver;
  // the bias choice only reaches the ladder while the follower runs
  assign biasActive = follower_q & ~saver;
  assign biasSixth = bias_q;
  assign regulatorRatio = ratio_q;
  assign externalResistor = ratio_q == lcdcd_pkg::RATIO_EXTERNAL;
  assign contrastCode = contrast_q;
  assign contrastFactor = lcdcd_pkg::CONTRAST_TOP - contrast_q;
  assign displayOn = displayOn_q;
  assign displayReverse = reverse_q;
  assign allPointsOn = allOn_q;
  assign segmentMirror = segMirror_q;
  assign commonReverse = comReverse_q;
  assign startLine = startLine_q;

  // ==========================================================
  // test mode and read-modify-write mode
  logic test_q, rmw_q;
  logic [6:0] rmwSave_q; // column at rmw entry
  logic [3:0] pagePtr_q; // page pointer, declared early; the rmw save uses only the column
  logic [6:0] columnPtr_q; // column pointer

  // test entry and its clears use different bytes, never together
  always_ff @(posedge clk) begin
    if (!rst_n || isReset || isDisplay) begin
      test_q <= 1'b0;
    end else if (isTest) begin
      test_q <= 1'b1;
    end
  end

  // rmw flag and the column it must return to
  always_ff @(posedge clk) begin
    if (!rst_n || isReset) begin
      rmw_q <= 1'b0;
      rmwSave_q <= 7'h00;
    end else if (isRmw) begin
      rmw_q <= 1'b1;
      rmwSave_q <= columnPtr_q;
    end else if (isEnd) begin
      rmw_q <= 1'b0;
    end
  end

  assign testMode = test_q;
  assign rmwActive = rmw_q;

  // ==========================================================
  // page and column pointers
  logic advance; // pointer steps after this access
  logic colWrap; // column at or past the last one
  logic [6:0] colInc;
  logic [3:0] pageInc;

  // in rmw mode a read leaves the column where it was
  assign advance = dataWrTake | (dataRdTake & ~rmw_q);
  assign colWrap = columnPtr_q >= lcdcd_pkg::COL_LAST;
  assign colInc = colWrap ? 7'h00 : columnPtr_q + 7'h01;
  assign pageInc = (pagePtr_q >= lcdcd_pkg::PAGE_LAST) ? 4'h0 : pagePtr_q + 4'h1;

  // column: set halves, rmw restore, then auto advance
  always_ff @(posedge clk) begin
    if (!rst_n || isReset) begin
      columnPtr_q <= 7'h00;
    end else if (isColHi) begin
      columnPtr_q <= {cmd[2:0], columnPtr_q[3:0]};
    end else if (isColLo) begin
      columnPtr_q <= {columnPtr_q[6:4], cmd[3:0]};
    end else if (isEnd && rmw_q) begin
      columnPtr_q <= rmwSave_q;
    end else if (advance) begin
      columnPtr_q <= colInc;
    end
  end

  // page: set by command, stepped when the column wraps
  always_ff @(posedge clk) begin
    if (!rst_n || isReset) begin
      pagePtr_q <= 4'h0;
    end else if (isPage) begin
      pagePtr_q <= cmd[3:0];
    end else if (advance && colWrap) begin
      pagePtr_q <= pageInc;
    end
  end

  assign pagePtr = pagePtr_q;
  assign columnPtr = columnPtr_q;

  // ==========================================================
  // display ram access, open during saver as well
  lcdcd_ram_if ramBus ();

  assign ramBus.wrEn = dataWrTake;
  assign ramBus.rdEn = dataRdTake;
  assign ramBus.page = pagePtr_q;
  assign ramBus.col = columnPtr_q;
  assign ramBus.wrData = cmd;

  lcdcd_display_ram ramInst (
    .clk(clk),
    .rst_n(rst_n),
    .ram(ramBus)
  );

  // a read shows the prefetched byte, so the first one after an
  // address change is stale; this is why the host reads once dummy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dataOut_q <= 8'h00;
      readBuf_q <= 8'h00;
      rdPend_q <= 1'b0;
    end else begin
      rdPend_q <= dataRdTake;
      if (dataRdTake) dataOut_q <= readBuf_q;
      if (rdPend_q) readBuf_q <= ramBus.rdData;
    end
  end

  assign hostDataOut = dataOut_q;
  assign hostDataOe = ~rdSync_q[1] & selSync_q[1];

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_rmwEnter;
    isRmw;
  endsequence
  sequence s_rmwLeave;
    rmw_q && isEnd;
  endsequence

  property p_power;
    isPower |=> {booster_q, regulator_q, follower_q} == $past(cmd[2:0]);
  endproperty
  a_power: assert property (p_power) else $error("power enables not loaded");

  property p_ratio;
    isRatio && cmd[2:0] == 3'h7 |=> externalResistor && regulatorRatio == 3'h7;
  endproperty
  a_ratio: assert property (p_ratio) else $error("external ratio not set");

  property p_volume;
    isVolume |=> contrastFactor == ~$past(cmd[4:0]);
  endproperty
  a_volume: assert property (p_volume) else $error("contrast not inverted");

  property p_bias;
    isBias |=> biasSixth == $past(cmd[0]);
  endproperty
  a_bias: assert property (p_bias) else $error("bias not loaded");

  property p_saver;
    isAllOn && cmd[0] && !displayOn_q |=> powerSaver && !oscEnable && !boosterOn
      && driversGrounded;
  endproperty
  a_saver: assert property (p_saver) else $error("saver not entered");

  property p_reset;
    isReset |=> !displayOn_q && !follower_q && pagePtr_q == 4'h0 && !test_q;
  endproperty
  a_reset: assert property (p_reset) else $error("soft reset incomplete");

  property p_testClear;
    test_q && isDisplay |=> !test_q;
  endproperty
  a_testClear: assert property (p_testClear) else $error("test not cleared");

  property p_display;
    isDisplay |=> displayOn == $past(cmd[0]);
  endproperty
  a_display: assert property (p_display) else $error("display bit wrong");

  property p_rmwEnter;
    s_rmwEnter |=> rmw_q && rmwSave_q == $past(columnPtr_q);
  endproperty
  a_rmwEnter: assert property (p_rmwEnter) else $error("rmw entry wrong");

  property p_rmwLeave;
    s_rmwLeave |=> !rmw_q && columnPtr_q == $past(rmwSave_q);
  endproperty
  a_rmwLeave: assert property (p_rmwLeave) else $error("column not restored");

  property p_wrap;
    dataWrTake && columnPtr_q == lcdcd_pkg::COL_LAST && pagePtr_q <= lcdcd_pkg::PAGE_LAST
      |=> columnPtr_q == 7'h00 && (pagePtr_q == $past(pagePtr_q) + 4'h1
      || (pagePtr_q == 4'h0 && $past(pagePtr_q) == lcdcd_pkg::PAGE_LAST));
  endproperty
  a_wrap: assert property (p_wrap) else $error("column wrap wrong");
endmodule // lcd_command_decoder

// File: hdl/lcdcd_display_ram.sv
// lcdcd_display_ram: byte store of the display, nine pages
// assumes: pointers from the decoder, same clock, no reset of contents
`timescale 1ns/1ns
module lcdcd_display_ram (
  input wire logic clk,
  input wire logic rst_n,
  lcdcd_ram_if.mem ram
);
  // contents survive every reset, only the read register clears
  logic [7:0] mem_q [lcdcd_pkg::RAM_DEPTH];
  logic [7:0] rdData_q;
  logic [9:0] index; // flat address
  logic addrOk; // pointer inside the ram
  logic [7:0] wrByte; // indicator page keeps only bit 0

  // ==========================================================
  // address and data selection
  assign addrOk = (ram.page < lcdcd_pkg::PAGE_COUNT) && (ram.col < lcdcd_pkg::COL_COUNT);
  assign index = {6'h00, ram.page} * lcdcd_pkg::RAM_STRIDE + {3'h0, ram.col};
  assign wrByte = (ram.page == lcdcd_pkg::PAGE_INDICATOR) ? {7'h00, ram.wrData[0]}
                                                          : ram.wrData;
  assign ram.rdData = rdData_q;

  // ==========================================================
  // storage: out of range writes are dropped
  always_ff @(posedge clk) begin
    if (ram.wrEn && addrOk) begin
      mem_q[index] <= wrByte;
    end
  end

  // read register, zero outside the ram
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_q <= 8'h00;
    end else if (ram.rdEn) begin
      rdData_q <= addrOk ? mem_q[index] : 8'h00;
    end
  end
endmodule // lcdcd_display_ram

// File: hdl/lcdcd_pkg.sv
// lcdcd_pkg: shared constants of the lcd command decoder
// assumes: byte wide host port, display ram of nine pages
package lcdcd_pkg;
  // ==========================================================
  // display ram geometry
  localparam logic [6:0] COL_LAST = 7'h65;      // last column
  localparam logic [6:0] COL_COUNT = 7'h66;     // columns per page
  localparam logic [3:0] PAGE_LAST = 4'h7;      // last page of the walk
  localparam logic [3:0] PAGE_COUNT = 4'h9;     // pages incl. indicator
  localparam logic [3:0] PAGE_INDICATOR = 4'h8; // only bit 0 stored
  localparam logic [9:0] RAM_STRIDE = 10'h066;  // bytes per page
  localparam int RAM_DEPTH = 918;               // nine pages of 102
  // ==========================================================
  // whole-byte commands
  localparam logic [7:0] CMD_RMW = 8'he0;
  localparam logic [7:0] CMD_END = 8'hee;
  localparam logic [7:0] CMD_RESET = 8'he2;
  localparam logic [7:0] CMD_NOP = 8'he3;
  // ==========================================================
  // seven-bit opcodes, low bit is the argument
  localparam logic [6:0] OP_DISPLAY = 7'h57;
  localparam logic [6:0] OP_REVERSE = 7'h53;
  localparam logic [6:0] OP_ALLON = 7'h52;
  localparam logic [6:0] OP_BIAS = 7'h51;
  localparam logic [6:0] OP_SEGDIR = 7'h50;
  // ==========================================================
  // shorter opcodes, compared against the top bits only; the test byte through a mask on bits 7, 6 and 4
  localparam logic [3:0] OP_PAGE = 4'hb;
  localparam logic [3:0] OP_COLHI = 4'h1;
  localparam logic [3:0] OP_COLLO = 4'h0;
  localparam logic [1:0] OP_START = 2'h1;
  localparam logic [2:0] OP_VOLUME = 3'h4;
  localparam logic [4:0] OP_POWER = 5'h05;
  localparam logic [4:0] OP_RATIO = 5'h04;
  localparam logic [4:0] OP_COMDIR = 5'h18;
  localparam logic [7:0] TEST_MASK = 8'hd0;
  localparam logic [7:0] TEST_VALUE = 8'hd0;
  // ==========================================================
  // field values and reset values
  localparam logic [2:0] RATIO_EXTERNAL = 3'h7;
  localparam logic [4:0] CONTRAST_TOP = 5'h1f;
  localparam logic [4:0] RST_CONTRAST = 5'h00;
  localparam logic [2:0] RST_RATIO = 3'h0;
  localparam logic [5:0] RST_START = 6'h00;
endpackage

// File: hdl/lcdcd_ram_if.sv
// lcdcd_ram_if: access port between decoder and display ram
// assumes: one access per cycle, read data one cycle later
`timescale 1ns/1ns
interface lcdcd_ram_if;
  logic wrEn; // write pulse
  logic rdEn; // read pulse
  logic [3:0] page; // page pointer
  logic [6:0] col; // column pointer
  logic [7:0] wrData; // byte to store
  logic [7:0] rdData; // byte fetched
  modport ctrl (output wrEn, rdEn, page, col, wrData, input rdData);
  modport mem (input wrEn, rdEn, page, col, wrData, output rdData);
endinterface

// File: verif/lcd_command_decoder_bench.sv
// lcd_command_decoder_bench: self-checking bench of the command decoder
// assumes: host model drives the port, state compared after each transfer
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module lcd_command_decoder_bench;
  // ==========================================================
  // signals and expected state
  typedef struct {logic [45:0] st; logic [1:0] kind; logic [7:0] rd;} lcdcd_note_type;
  lcdcd_note_type notes[$]; // expected results, oldest first
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire logic cmdDataSelect, hostReadStrobeN, hostWriteStrobeN;
  wire logic [7:0] hostDataIn;
  logic [7:0] hostDataOut;
  logic hostDataOe, displayOn, displayReverse, allPointsOn, powerSaver, oscEnable;
  logic boosterOn, regulatorOn, followerOn, externalResistor, biasSixth, biasActive;
  logic segmentMirror, commonReverse, rmwActive, testMode, driversGrounded;
  logic [2:0] regulatorRatio;
  logic [4:0] contrastCode, contrastFactor;
  logic [5:0] startLine;
  logic [3:0] pagePtr;
  logic [6:0] columnPtr;
  int num_errors = 0;
  int check_count = 0;
  logic dOn, rev, allOn, bias, segment_out, common_out, rmw, tst; // expected flags
  logic [2:0] pwr, ratio;
  logic [4:0] code;
  logic [5:0] start;
  logic [3:0] page;
  logic [6:0] col, savedCol;
  logic [31:0] r;
  wire logic [45:0] obsSeen = {displayOn, displayReverse, allPointsOn, powerSaver,
    oscEnable, boosterOn, regulatorOn, followerOn, regulatorRatio, externalResistor,
    contrastCode, contrastFactor, biasSixth, biasActive, segmentMirror, commonReverse,
    startLine, pagePtr, columnPtr, rmwActive, testMode, driversGrounded};
  always #25 clk = ~clk;
  lcd_command_decoder i_lcd_command_decoder (.clk(clk), .rst_n(rst_n),
    .cmdDataSelect(cmdDataSelect), .hostReadStrobeN(hostReadStrobeN),
    .hostWriteStrobeN(hostWriteStrobeN), .hostDataIn(hostDataIn),
    .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .displayOn(displayOn),
    .displayReverse(displayReverse), .allPointsOn(allPointsOn), .powerSaver(powerSaver),
    .oscEnable(oscEnable), .boosterOn(boosterOn), .regulatorOn(regulatorOn),
    .followerOn(followerOn), .regulatorRatio(regulatorRatio),
    .externalResistor(externalResistor), .contrastCode(contrastCode),
    .contrastFactor(contrastFactor), .biasSixth(biasSixth), .biasActive(biasActive),
    .segmentMirror(segmentMirror), .commonReverse(commonReverse), .startLine(startLine),
    .pagePtr(pagePtr), .columnPtr(columnPtr), .rmwActive(rmwActive), .testMode(testMode),
    .driversGrounded(driversGrounded));
  lcdcd_host_model i_lcdcd_host_model (.clk(clk), .cmdDataSelect(cmdDataSelect),
    .hostReadStrobeN(hostReadStrobeN), .hostWriteStrobeN(hostWriteStrobeN),
    .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe));
  // ==========================================================
  // expectation helpers
  // saver is derived, never stored, so it is recomputed here
  function automatic logic [45:0] expObs();
    logic sv;
    sv = !dOn & allOn;
    return {dOn, rev, allOn, sv, !sv, pwr[2] & !sv, pwr[1] & !sv, pwr[0] & !sv, ratio,
      ratio == 3'h7, code, 5'h1f - code, bias, pwr[0] & !sv, segment_out, common_out, start, page, col,
      rmw, tst, sv};
  endfunction
  task automatic clearAll();
    {dOn, rev, allOn, bias, segment_out, common_out, rmw, tst, pwr, ratio, code, start, page, col} = '0;
  endtask
  task automatic note(input logic [1:0] k, input logic [7:0] d);
    lcdcd_note_type n;
    n.st = expObs();
    n.kind = k;
    n.rd = d;
    notes.push_back(n);
  endtask
  // column walk: wrap after the last column moves to the next page
  task automatic advance();
    if (col >= 7'h65) begin
      col = 7'h00;
      page = (page >= 4'h7) ? 4'h0 : page + 4'h1;
    end else begin
      col = col + 7'h01;
    end
  endtask
  // command write: expected state updated from the byte, then sent
  task automatic cmd(input logic [7:0] b);
    casez (b)
      8'b0000????: col[3:0] = b[3:0];
      8'b0001????: col[6:4] = b[2:0];
      8'b00100???: ratio = b[2:0];
      8'b00101???: pwr = b[2:0];
      8'b01??????: start = b[5:0];
      8'b100?????: code = b[4:0];
      8'b1010000?: segment_out = b[0];
      8'b1010001?: bias = b[0];
      8'b1010010?: allOn = b[0];
      8'b1010011?: rev = b[0];
      8'b1010111?: {dOn, tst} = {b[0], 1'b0};
      8'b1011????: page = b[3:0];
      8'b1100????: common_out = b[3];
      8'b11?1????: tst = 1'b1;
      8'he0: {rmw, savedCol} = {1'b1, col};
      8'hee: if (rmw) {rmw, col} = {1'b0, savedCol};
      8'he2: clearAll();
      default: ; // unlisted bytes change nothing
    endcase
    note(2'h0, 8'h00);
    i_lcdcd_host_model.wr(1'b0, b);
  endtask
  task automatic dwr(input logic [7:0] b);
    advance();
    note(2'h0, 8'h00);
    i_lcdcd_host_model.wr(1'b1, b);
  endtask
  task automatic drd(input logic [1:0] k, input logic [7:0] d);
    if (!rmw) advance();
    note(k, d);
    i_lcdcd_host_model.rd();
  endtask
  // ==========================================================
  // result watcher and closing
  always @(i_lcdcd_host_model.opDone) begin
    lcdcd_note_type n;
    if (notes.size() == 0) begin
      num_errors++;
      $display("[FAIL] result without expectation");
    end else begin
      n = notes.pop_front();
      `CHECK("state", n.st, obsSeen)
      if (n.kind != 2'h0) `CHECK("oe", 1'b1, i_lcdcd_host_model.lastRead[8])
      if (n.kind == 2'h2) `CHECK("read", n.rd, i_lcdcd_host_model.lastRead[7:0])
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    $display("[FAIL] run timed out");
    stop_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(20));
    clearAll();
    savedCol = 7'h00;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    `CHECK("reset", expObs(), obsSeen)
    r = $urandom();
    cmd({5'b00101, r[2:0]});
    cmd(8'h2f);
    for (int i = 0; i < 8; i++) cmd({5'b00100, i[2:0]});
    cmd({3'b100, r[7:3]});
    cmd(8'h9f);
    cmd(8'ha3);
    cmd(8'ha1);
    cmd(8'ha7);
    cmd({4'hc, 1'b1, r[10:8]});
    cmd({2'b01, r[16:11]});
    cmd(8'hea);
    cmd(8'ha8);
    cmd(8'he3);
    dwr(8'hae);
    cmd(8'haf);
    cmd(8'ha5);
    cmd(8'hae);
    cmd({2'b01, r[22:17]});
    dwr(r[30:23]);
    cmd(8'ha4);
    cmd({2'b11, r[24], 1'b1, r[28:25]});
    cmd(8'hae);
    cmd(8'hdf);
    cmd(8'he2);
    cmd({4'hb, 1'b0, r[31:29]});
    cmd(8'h1e);
    cmd(8'h05);
    dwr(8'h11);
    cmd(8'hb7);
    cmd(8'h16);
    cmd(8'h05);
    dwr(8'h22);
    cmd(8'hb2);
    cmd(8'h11);
    cmd(8'h00);
    dwr(8'h3c);
    dwr(8'hc3);
    cmd(8'h00);
    cmd(8'he0);
    drd(2'h1, 8'h00);
    drd(2'h2, 8'h3c);
    dwr(8'h99);
    cmd(8'hb5);
    cmd(8'hee);
    drd(2'h1, 8'h00);
    cmd(8'ha7);
    cmd(8'hd0);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    clearAll();
    repeat (3) @(negedge clk);
    `CHECK("pin reset", expObs(), obsSeen)
    stop_test();
  end
endmodule // lcd_command_decoder_bench

// File: verif/lcdcd_host_model.sv
// lcdcd_host_model: host processor on the parallel command/data port
// assumes: device samples strobes through two sync flops at clk
`timescale 1ns/1ns
module lcdcd_host_model (
  input wire logic clk,
  output logic cmdDataSelect,
  output logic hostReadStrobeN,
  output logic hostWriteStrobeN,
  output logic [7:0] hostDataIn,
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOe
);
  // ==========================================================
  // transfer tasks
  event opDone; // fires once a transfer has fully settled
  logic [8:0] lastRead; // {output enable, data} seen during a read
  initial begin
    cmdDataSelect = 1'b0;
    hostReadStrobeN = 1'b1;
    hostWriteStrobeN = 1'b1;
    hostDataIn = 8'h00;
    lastRead = 9'h000;
  end
  // strobe low 4 clocks, data held 4 clocks after release
  task automatic wr(input logic sel, input logic [7:0] b);
    @(negedge clk);
    cmdDataSelect = sel;
    hostDataIn = b;
    hostWriteStrobeN = 1'b0;
    repeat (4) @(negedge clk);
    hostWriteStrobeN = 1'b1;
    repeat (4) @(negedge clk);
    hostDataIn = ~b; // released bus must not look like the last byte
    repeat (2) @(negedge clk);
    -> opDone;
  endtask
  // read strobe held until the answer has settled, then a long gap
  task automatic rd;
    @(negedge clk);
    cmdDataSelect = 1'b1;
    hostReadStrobeN = 1'b0;
    repeat (4) @(negedge clk);
    lastRead = {hostDataOe, hostDataOut};
    hostReadStrobeN = 1'b1;
    repeat (5) @(negedge clk);
    -> opDone;
  endtask
endmodule // lcdcd_host_model
